// ### src/circ_pkg.sv
// Constants for the circular buffer address generator
package circ_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] CONTROL_IDX   = 3'h0;
  localparam logic [2:0] X_START_IDX   = 3'h1;
  localparam logic [2:0] X_END_IDX     = 3'h2;
  localparam logic [2:0] Y_START_IDX   = 3'h3;
  localparam logic [2:0] Y_END_IDX     = 3'h4;

  // Control field positions
  localparam int X_SEL_LSB  = 0;
  localparam int Y_SEL_LSB  = 4;
  localparam int SEL_W      = 4;
  localparam int Y_EN_BIT   = 14;
  localparam int X_EN_BIT   = 15;

  // Selector value that turns a space off
  localparam logic [3:0] SEL_OFF = 4'hF;

  // Reset values
  localparam logic [15:0] CONTROL_RST = 16'h00FF;
  localparam logic [15:0] ADDR_RST    = 16'h0000;

  // Writable control bits; the rest read as zero
  localparam logic [15:0] CONTROL_MASK = 16'hC0FF;

  // Channel numbering
  localparam int CH_X_READ  = 0;
  localparam int CH_X_WRITE = 1;
  localparam int CH_Y       = 2;
  localparam int NUM_CH     = 3;

  // Register port timing: read data one cycle after the strobe
  localparam int READ_LATENCY = 1;

endpackage

// ### src/circular_buffer_address_gen.sv
// Circular buffer address generator for the X and Y data spaces
//
// Contract
// - There is one circular buffer in X space and one in Y space, each configured on its own.
// - The X buffer also serves program-space pointers, so X wrapping applies to both spaces.
// - Any working register except 15 may be chosen as the wrapped pointer, though frame and stack pointers are unwise.
// - Power-of-two buffers work both ways, since both the lower and upper bounds are checked.
// - Each space has a 16-bit start register and a 16-bit end register bounding its buffer.
// - Y-space calculations assume word data, so the lowest address bit is taken as zero.
// - Buffer length comes from the start and end difference alone, up to 32K words.
// - An all-ones X selector turns wrapping off for both the X read and X write generators.
// - An all-ones Y selector turns wrapping off for the Y generator.
// - The X selector is control bits 3..0 and X wraps only when it is not all ones and bit 15 is set.
// - The Y selector is control bits 7..4 and Y wraps only when it is not all ones and bit 14 is set.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps

module circular_buffer_address_gen #(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 16
) (
  input  wire logic                                clk_i,
  input  wire logic                                srst_i,
  // Register port
  input  wire logic [ADDR_W-1:0]                   reg_addr_i,
  input  wire logic [DATA_W-1:0]                   reg_wdata_i,
  input  wire logic                                reg_we_i,
  input  wire logic                                reg_re_i,
  output logic      [DATA_W-1:0]                   reg_rdata_o,
  // Address generator requests, one per channel
  input  wire logic [circ_pkg::NUM_CH-1:0]         step_valid_i,
  input  wire logic [circ_pkg::NUM_CH-1:0][3:0]    step_reg_i,
  input  wire logic [circ_pkg::NUM_CH-1:0][15:0]   step_ptr_i,
  input  wire logic [circ_pkg::NUM_CH-1:0][15:0]   step_mod_i,
  // Modified pointers, one cycle after the request
  output logic      [circ_pkg::NUM_CH-1:0]         next_valid_o,
  output logic      [circ_pkg::NUM_CH-1:0][15:0]   next_ptr_o,
  output logic      [circ_pkg::NUM_CH-1:0]         next_wrapped_o,
  // Space status
  output logic                                     x_circular_active_o,
  output logic                                     y_circular_active_o
);
  import circ_pkg::*;

  // Refuse a port the decode cannot serve
  initial begin
    if (ADDR_W < 3) begin
      $error("ADDR_W must be at least 3");
    end
    if (DATA_W != 16) begin
      $error("DATA_W must be 16");
    end
  end

  // Configuration registers
  // separate X and Y setup
  logic [15:0] circular_control_reg;
  logic [15:0] x_buffer_start_addr_reg;
  logic [15:0] x_buffer_end_addr_reg;
  logic [15:0] y_buffer_start_addr_reg;
  logic [15:0] y_buffer_end_addr_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Decoded control fields
  logic [3:0]  x_pointer_select;
  logic [3:0]  y_pointer_select;
  logic        x_circular_enable;
  logic        y_circular_enable;
  logic        x_active;
  logic        y_active;

  // Index match for the register port
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [2:0] idx);
    hit = (addr == ADDR_W'(idx));
  endfunction

  // Control register write
  // X and Y fields in control
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      circular_control_reg <= CONTROL_RST;
    end else if (reg_we_i && hit(reg_addr_i, CONTROL_IDX)) begin
      circular_control_reg <= reg_wdata_i & CONTROL_MASK;
    end
  end

  // X bound registers
  // 16-bit X bounds
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      x_buffer_start_addr_reg <= ADDR_RST;
      x_buffer_end_addr_reg   <= ADDR_RST;
    end else if (reg_we_i) begin
      if (hit(reg_addr_i, X_START_IDX)) begin
        x_buffer_start_addr_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, X_END_IDX)) begin
        x_buffer_end_addr_reg <= reg_wdata_i;
      end
    end
  end

  // Y bound registers
  // 16-bit Y bounds
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      y_buffer_start_addr_reg <= ADDR_RST;
      y_buffer_end_addr_reg   <= ADDR_RST;
    end else if (reg_we_i) begin
      if (hit(reg_addr_i, Y_START_IDX)) begin
        y_buffer_start_addr_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, Y_END_IDX)) begin
        y_buffer_end_addr_reg <= reg_wdata_i;
      end
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (hit(reg_addr_i, CONTROL_IDX)) begin
      rdata_next = circular_control_reg;
    end else if (hit(reg_addr_i, X_START_IDX)) begin
      rdata_next = x_buffer_start_addr_reg;
    end else if (hit(reg_addr_i, X_END_IDX)) begin
      rdata_next = x_buffer_end_addr_reg;
    end else if (hit(reg_addr_i, Y_START_IDX)) begin
      rdata_next = y_buffer_start_addr_reg;
    end else if (hit(reg_addr_i, Y_END_IDX)) begin
      rdata_next = y_buffer_end_addr_reg;
    end
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= 16'h0000;
    end else if (reg_re_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_reg;

  // Field extraction
  assign x_pointer_select  = circular_control_reg[X_SEL_LSB +: SEL_W];
  assign y_pointer_select  = circular_control_reg[Y_SEL_LSB +: SEL_W];
  assign x_circular_enable = circular_control_reg[X_EN_BIT];
  assign y_circular_enable = circular_control_reg[Y_EN_BIT];

  // Space enables
  // all-ones X or Y selector off
  assign x_active = x_circular_enable && (x_pointer_select != SEL_OFF);
  assign y_active = y_circular_enable && (y_pointer_select != SEL_OFF);

  assign x_circular_active_o = x_active;
  assign y_circular_active_o = y_active;

  // One pointer step with wrap; returns {wrapped, address}.
  // Length is implied by the bounds, so no length register
  // can fall out of step with them.
  function automatic logic [16:0] circ_step(
    input logic [15:0] ptr,
    input logic [15:0] modv,
    input logic [15:0] lo,
    input logic [15:0] hi,
    input logic        word_only,
    input logic        on
  );
    logic [15:0] lo_w;
    logic [15:0] hi_w;
    logic [16:0] len;
    logic [16:0] sum;
    logic [15:0] res;
    logic        wrap;
    lo_w = word_only ? {lo[15:1], 1'b0} : lo;
    hi_w = word_only ? {hi[15:1], 1'b1} : hi;
    len  = {1'b0, hi_w} - {1'b0, lo_w} + 17'h00001;
    sum  = {1'b0, ptr} + {modv[15], modv};
    res  = sum[15:0];
    wrap = 1'b0;
    if (on && (modv != 16'h0000)) begin
      if (!modv[15] && (sum > {1'b0, hi_w})) begin
        res  = 16'(sum - len);
        wrap = 1'b1;
      end else if (modv[15] && (sum[16] || (sum[15:0] < lo_w))) begin
        res  = 16'(sum + len);
        wrap = 1'b1;
      end
    end
    if (word_only) begin
      res[0] = 1'b0;
    end
    circ_step = {wrap, res};
  endfunction

  // Per-channel step units; X read and X write share the X setup.
  // X pointers also reach program space, so no space qualifier
  // is applied here.
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic        is_y;
      logic        sel_hit;
      logic [15:0] lo;
      logic [15:0] hi;
      logic [16:0] step;

      assign is_y = (ch == CH_Y);
      assign lo   = is_y ? y_buffer_start_addr_reg : x_buffer_start_addr_reg;
      assign hi   = is_y ? y_buffer_end_addr_reg : x_buffer_end_addr_reg;

      // Only the selected working register wraps
      // any register but 15 selectable
      assign sel_hit = is_y ?
        (y_active && (step_reg_i[ch] == y_pointer_select)) :
        (x_active && (step_reg_i[ch] == x_pointer_select));

      assign step = circ_step(step_ptr_i[ch], step_mod_i[ch], lo, hi,
                              is_y, sel_hit);

      // Registered result; holds until the next request
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          next_valid_o[ch]   <= 1'b0;
          next_ptr_o[ch]     <= 16'h0000;
          next_wrapped_o[ch] <= 1'b0;
        end else begin
          next_valid_o[ch] <= step_valid_i[ch];
          if (step_valid_i[ch]) begin
            next_ptr_o[ch]     <= step[15:0];
            next_wrapped_o[ch] <= step[16];
          end
        end
      end
    end
  endgenerate

endmodule

// ### test/circ_checker.sv
// Port assertions for the circular address generator
`timescale 1ns/1ps
module circ_checker
  import circ_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 16
) (
  input wire logic                                 clk_i,
  input wire logic                                 srst_i,
  input wire logic [ADDR_W-1:0]                    reg_addr_i,
  input wire logic [DATA_W-1:0]                    reg_wdata_i,
  input wire logic                                 reg_we_i,
  input wire logic                                 reg_re_i,
  input wire logic [DATA_W-1:0]                    reg_rdata_o,
  input wire logic [circ_pkg::NUM_CH-1:0]          step_valid_i,
  input wire logic [circ_pkg::NUM_CH-1:0][15:0]    step_ptr_i,
  input wire logic [circ_pkg::NUM_CH-1:0][15:0]    step_mod_i,
  input wire logic [circ_pkg::NUM_CH-1:0][15:0]    next_ptr_o,
  input wire logic [circ_pkg::NUM_CH-1:0]          next_wrapped_o,
  input wire logic                                 x_circular_active_o,
  input wire logic                                 y_circular_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Bound write then read of the same bound
  sequence s_wr_rd;
    reg_we_i && reg_addr_i >= 3'h1 && reg_addr_i <= 3'h4 ##1 reg_re_i && $stable(reg_addr_i);
  endsequence
  a_bound_readback: assert property (s_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("bound register read back wrong");
  a_rdata_stands: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0)
    else $error("read data outside its cycle");
  a_x_enable: assert property (reg_we_i && reg_addr_i == CONTROL_IDX |=> x_circular_active_o ==
    ($past(reg_wdata_i[X_EN_BIT]) && $past(reg_wdata_i[3:0]) != SEL_OFF))
    else $error("X active flag wrong");
  a_y_enable: assert property (reg_we_i && reg_addr_i == CONTROL_IDX |=> y_circular_active_o ==
    ($past(reg_wdata_i[Y_EN_BIT]) && $past(reg_wdata_i[7:4]) != SEL_OFF))
    else $error("Y active flag wrong");
  a_x_off_pass: assert property (step_valid_i[CH_X_READ] && !x_circular_active_o |=> !next_wrapped_o[0]
    && next_ptr_o[0] == $past(step_ptr_i[0] + step_mod_i[0]))
    else $error("inactive X step altered");
  a_y_off_pass: assert property (step_valid_i[CH_Y] && !y_circular_active_o |=>
    next_ptr_o[2] == ($past(step_ptr_i[2] + step_mod_i[2]) & 16'hFFFE))
    else $error("inactive Y step altered");
  a_y_word: assert property (step_valid_i[CH_Y] |=> !next_ptr_o[2][0])
    else $error("Y pointer odd");
  a_wrap_flag: assert property (step_valid_i[CH_X_WRITE] |=> next_wrapped_o[1] ==
    (next_ptr_o[1] != $past(step_ptr_i[1] + step_mod_i[1])))
    else $error("wrap flag disagrees with pointer");
endmodule

bind circular_buffer_address_gen circ_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_circ_checker (
  .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .step_valid_i(step_valid_i),
  .step_ptr_i(step_ptr_i), .step_mod_i(step_mod_i), .next_ptr_o(next_ptr_o),
  .next_wrapped_o(next_wrapped_o), .x_circular_active_o(x_circular_active_o),
  .y_circular_active_o(y_circular_active_o));

// ### test/core_agen_model.sv
// Behavioural core address generator issuing pointer steps
`timescale 1ns/1ps
module core_agen_model (
  input  wire logic                             clk_i,
  output logic [circ_pkg::NUM_CH-1:0]           step_valid_o,
  output logic [circ_pkg::NUM_CH-1:0][3:0]      step_reg_o,
  output logic [circ_pkg::NUM_CH-1:0][15:0]     step_ptr_o,
  output logic [circ_pkg::NUM_CH-1:0][15:0]     step_mod_o
);
  import circ_pkg::*;
  // Idle at time zero
  initial begin
    step_valid_o = '0;
    step_reg_o = '0;
    step_ptr_o = '0;
    step_mod_o = '0;
  end
  // One request, optionally after a stall
  task step(input int ch, input logic [3:0] r, input logic [15:0] p, input logic [15:0] m, input int gap);
    repeat (gap) @(posedge clk_i);
    @(posedge clk_i);
    step_valid_o[ch] <= 1'b1;
    step_reg_o[ch] <= r;
    step_ptr_o[ch] <= p;
    step_mod_o[ch] <= m;
    @(posedge clk_i);
    step_valid_o[ch] <= 1'b0;
    // Released lines show junk, not the old value
    step_ptr_o[ch] <= ~p;
    step_mod_o[ch] <= ~m;
  endtask
endmodule

// ### test/test_circular_buffer_address_gen.sv
// Self-checking bench for the circular address generator
`timescale 1ns/1ps
module test_circular_buffer_address_gen;
  import circ_pkg::*;
  logic                         clk_i = 1'b0;
  logic                         srst_i = 1'b1;
  logic [2:0]                   reg_addr_i = '0;
  logic [15:0]                  reg_wdata_i = '0;
  logic                         reg_we_i = 1'b0;
  logic                         reg_re_i = 1'b0;
  logic [15:0]                  reg_rdata_o;
  logic [NUM_CH-1:0]            step_valid_i, next_valid_o, next_wrapped_o;
  logic [NUM_CH-1:0][3:0]       step_reg_i;
  logic [NUM_CH-1:0][15:0]      step_ptr_i, step_mod_i, next_ptr_o;
  logic                         x_circular_active_o, y_circular_active_o;
  int                           fails = 0;
  int                           n_tests = 0;
  int                           cycles = 0;
  always #25 clk_i = ~clk_i;
  circular_buffer_address_gen i_circular_buffer_address_gen (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .step_valid_i(step_valid_i), .step_reg_i(step_reg_i),
    .step_ptr_i(step_ptr_i), .step_mod_i(step_mod_i), .next_valid_o(next_valid_o),
    .next_ptr_o(next_ptr_o), .next_wrapped_o(next_wrapped_o),
    .x_circular_active_o(x_circular_active_o), .y_circular_active_o(y_circular_active_o));
  core_agen_model i_core_agen_model (.clk_i(clk_i), .step_valid_o(step_valid_i),
    .step_reg_o(step_reg_i), .step_ptr_o(step_ptr_i), .step_mod_o(step_mod_i));
  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Write strobe is left up; the next read lowers it
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_re_i <= 1'b0;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, e);
  endtask
  // Y requests come after a two-cycle stall to exercise idle gaps between requests
  task stp(input int ch, input logic [15:0] p, m, e, input logic w);
    i_core_agen_model.step(ch, 4'h1, p, m, ch == CH_Y ? 2 : 0);
    #1;
    chk("next_valid", {15'h0, next_valid_o[ch]}, 16'h0001);
    chk("next_ptr", next_ptr_o[ch], e);
    chk("wrapped", {15'h0, next_wrapped_o[ch]}, {15'h0, w});
  endtask
  // Hang guard, far above the run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd(3'(i), i == 0 ? CONTROL_RST : ADDR_RST);
    wr(CONTROL_IDX, 16'hFFFF);
    rd(CONTROL_IDX, CONTROL_MASK);
    chk("x_active", {15'h0, x_circular_active_o}, 16'h0000);
    wr(X_START_IDX, 16'h1100);
    wr(CONTROL_IDX, 16'h8001);
    wr(X_END_IDX, 16'h1163);
    rd(X_END_IDX, 16'h1163);
    chk("x_active", {15'h0, x_circular_active_o}, 16'h0001);
    stp(CH_X_READ, 16'h1163, 16'h0001, 16'h1100, 1'b1);
    stp(CH_X_WRITE, 16'h1100, 16'hFFFE, 16'h1162, 1'b1);
    i_core_agen_model.step(CH_X_READ, 4'h2, 16'h1163, 16'h0001, 0);
    #1;
    chk("other_reg", next_ptr_o[0], 16'h1164);
    wr(Y_START_IDX, 16'h2000);
    wr(CONTROL_IDX, 16'hC011);
    wr(Y_END_IDX, 16'h201F);
    rd(Y_END_IDX, 16'h201F);
    stp(CH_Y, 16'h201E, 16'h0002, 16'h2000, 1'b1);
    stp(CH_Y, 16'h2000, 16'hFFFE, 16'h201E, 1'b1);
    stp(CH_Y, 16'h2005, 16'h0000, 16'h2004, 1'b0);
    stp(CH_X_READ, 16'h1163, 16'h0001, 16'h1100, 1'b1);
    wr(CONTROL_IDX, 16'h80FF);
    rd(CONTROL_IDX, 16'h80FF);
    stp(CH_X_WRITE, 16'h1163, 16'h0001, 16'h1164, 1'b0);
    stp(CH_X_READ, 16'h1163, 16'h0001, 16'h1164, 1'b0);
    wr(CONTROL_IDX, 16'h40F1);
    rd(CONTROL_IDX, 16'h40F1);
    stp(CH_Y, 16'h201E, 16'h0002, 16'h2020, 1'b0);
    wr(CONTROL_IDX, 16'h0011);
    rd(CONTROL_IDX, 16'h0011);
    stp(CH_Y, 16'h201E, 16'h0002, 16'h2020, 1'b0);
    end_sim();
  end
endmodule
